// ### hw/tws_pkg.sv
package tws_pkg;

  // register map geometry
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 16;
  localparam int BYTE_W = 8;

  // bus addresses (write-mode form, direction bit clear)
  localparam logic [7:0] BUS_ADDR_SEL_LOW = 8'h90;
  localparam logic [7:0] BUS_ADDR_SEL_HIGH = 8'hB8;

  // register index that carries the low byte in byte-wide access
  localparam logic [7:0] LOW_BYTE_ALIAS_REGISTER = 8'h7F;

  // bits per byte, as seen by the bit counter
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] CNT_FIRST_TX = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  // reset values
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // serial engine states
  typedef enum logic [3:0] {
    TWS_IDLE,
    TWS_DEV_ADDR,
    TWS_ACK_DEV,
    TWS_REG_ADDR,
    TWS_ACK_REG,
    TWS_WR_DATA,
    TWS_ACK_WR,
    TWS_RD_DATA,
    TWS_ACK_RD,
    TWS_IGNORE
  } tws_state_e;

endpackage

// ### hw/tws_reg_mem.sv
`timescale 1ns/10ps
// register array: one write port, two registered read ports
module tws_reg_mem #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 16
) (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic [ADDR_W-1:0] rd_a_addr_in,
  output logic [DATA_W-1:0] rd_a_data_out,
  input wire logic [ADDR_W-1:0] rd_b_addr_in,
  output logic [DATA_W-1:0] rd_b_data_out
);

  // refuse geometries the logic cannot serve
  if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1)
  begin : g_bad_geometry
    $error("tws_reg_mem: unsupported width");
  end

  logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

  // write port
  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
    begin
      mem_ff[wr_addr_in] <= wr_data_in;
    end
  end

  // registered read ports
  always_ff @(posedge clk_in)
  begin
    rd_a_data_out <= mem_ff[rd_a_addr_in];
    rd_b_data_out <= mem_ff[rd_b_addr_in];
  end

endmodule

// ### hw/tws_register_slave.sv
`timescale 1ns/10ps
// Behaviour
// - address 0x90 when select low, 0xB8 high
// - select high: write 0xB8, read 0xB9
// - address byte: seven bits, direction LSB
// - acknowledge own address byte by pulling low
// - write carries register address byte, acknowledged
// - acknowledge every written byte; two form word
// - pointer advances after each written word
// - device sends bytes, master acknowledges each
// - pointer advances after each word read
// - master nack ends read; device releases line
// - low byte reached through alias register 127
// - bus idle when both lines high
// - data falling with clock high is start
// - data rising with clock high is stop
// - data changes only while clock low
// - receiver pulls low during acknowledge pulse
// - line left high during pulse is nack
// - data line only pulled low or released
// - registers are 16 bits, two access styles
// - register written only when whole word arrives
module tws_register_slave (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic link_sample_clk_in,
  input wire logic bus_address_select_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_out,
  input wire logic [tws_pkg::REG_ADDR_W-1:0] cfg_addr_in,
  output logic [tws_pkg::REG_DATA_W-1:0] cfg_data_out
);
  import tws_pkg::*;

  // byte to send next: upper, lower, or alias low byte
  function automatic logic [7:0] tx_byte(input logic [7:0] ptr,
                                         input logic sel,
                                         input logic [15:0] word,
                                         input logic [7:0] alias_lo);
    logic [7:0] res;
    res = sel ? word[7:0] : word[15:8];
    if (ptr == LOW_BYTE_ALIAS_REGISTER)
    begin
      res = alias_lo;
    end
    return res;
  endfunction

  // link-domain reset, released synchronously
  logic lrst_meta_ff;
  logic lrst_n_ff;
  always_ff @(posedge link_sample_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      lrst_meta_ff <= 1'b0;
      lrst_n_ff <= 1'b0;
    end
    else
    begin
      lrst_meta_ff <= 1'b1;
      lrst_n_ff <= lrst_meta_ff;
    end
  end

  // pin synchronisers; bus is sampled by the link clock
  logic scl_meta_ff, scl_sync_ff, scl_prev_ff;
  logic sda_meta_ff, sda_sync_ff, sda_prev_ff;
  logic asel_meta_ff, asel_sync_ff;
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      asel_meta_ff <= 1'b0;
      asel_sync_ff <= 1'b0;
    end
    else
    begin
      scl_meta_ff <= serial_clock_in;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= serial_data_line_in;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
      asel_meta_ff <= bus_address_select_in;
      asel_sync_ff <= asel_meta_ff;
    end
  end

  // bus events
  logic rise_ev, fall_ev, start_ev, stop_ev, clk_high;
  assign clk_high = scl_sync_ff && scl_prev_ff;
  assign rise_ev = scl_sync_ff && !scl_prev_ff;
  assign fall_ev = !scl_sync_ff && scl_prev_ff;
  assign start_ev = clk_high && sda_prev_ff && !sda_sync_ff;
  assign stop_ev = clk_high && !sda_prev_ff && sda_sync_ff;

  tws_state_e state_ff;
  logic [3:0] cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic rw_ff;
  logic mack_ff;
  logic drive_low_ff;
  logic [7:0] ptr_ff;
  logic sel_ff;
  logic [7:0] wr_hi_ff;
  logic [7:0] alias_addr_ff;
  logic [7:0] alias_lo_ff;
  logic [15:0] word_ff;

  // own address from the select pin; direction bit ignored
  logic [7:0] own_addr;
  logic addr_match;
  logic byte_end;
  logic is_alias;
  logic [7:0] next_tx;
  logic regaddr_done, wrbyte_done, rdbyte_done;
  assign own_addr = asel_sync_ff ? BUS_ADDR_SEL_HIGH
                                 : BUS_ADDR_SEL_LOW;
  assign addr_match = (rx_ff[7:1] == own_addr[7:1]);
  assign byte_end = fall_ev && (cnt_ff == BITS_PER_BYTE);
  assign is_alias = (ptr_ff == LOW_BYTE_ALIAS_REGISTER);
  assign next_tx = tx_byte(ptr_ff, sel_ff, word_ff, alias_lo_ff);
  assign regaddr_done = (state_ff == TWS_REG_ADDR) && byte_end;
  assign wrbyte_done = (state_ff == TWS_WR_DATA) && byte_end;
  assign rdbyte_done = (state_ff == TWS_RD_DATA) && byte_end;

  // protocol sequencer; stop returns to idle
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      state_ff <= TWS_IDLE;
    end
    else if (start_ev)
    begin
      state_ff <= TWS_DEV_ADDR;
    end
    else if (stop_ev)
    begin
      state_ff <= TWS_IDLE;
    end
    else
    begin
      case (state_ff)
        TWS_DEV_ADDR:
          if (byte_end)
          begin
            state_ff <= addr_match ? TWS_ACK_DEV : TWS_IGNORE;
          end
        TWS_ACK_DEV:
          if (fall_ev)
          begin
            state_ff <= rw_ff ? TWS_RD_DATA : TWS_REG_ADDR;
          end
        TWS_REG_ADDR:
          if (byte_end)
          begin
            state_ff <= TWS_ACK_REG;
          end
        TWS_ACK_REG, TWS_ACK_WR:
          if (fall_ev)
          begin
            state_ff <= TWS_WR_DATA;
          end
        TWS_WR_DATA:
          if (byte_end)
          begin
            state_ff <= TWS_ACK_WR;
          end
        TWS_RD_DATA:
          if (byte_end)
          begin
            state_ff <= TWS_ACK_RD;
          end
        TWS_ACK_RD:
          if (fall_ev)
          begin
            state_ff <= mack_ff ? TWS_RD_DATA : TWS_IGNORE;
          end
        default:
          state_ff <= state_ff;
      endcase
    end
  end

  // bit counter: counts up on clock rise in receive, on clock fall in transmit
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      cnt_ff <= CNT_ZERO;
    end
    else if (start_ev || stop_ev)
    begin
      cnt_ff <= CNT_ZERO;
    end
    else
    begin
      case (state_ff)
        TWS_DEV_ADDR, TWS_REG_ADDR, TWS_WR_DATA:
          if (rise_ev)
          begin
            cnt_ff <= cnt_ff + 4'h1;
          end
          else if (byte_end)
          begin
            cnt_ff <= CNT_ZERO;
          end
        TWS_ACK_DEV:
          if (fall_ev)
          begin
            cnt_ff <= rw_ff ? CNT_FIRST_TX : CNT_ZERO;
          end
        TWS_ACK_RD:
          if (fall_ev)
          begin
            cnt_ff <= CNT_FIRST_TX;
          end
        TWS_ACK_REG, TWS_ACK_WR:
          if (fall_ev)
          begin
            cnt_ff <= CNT_ZERO;
          end
        TWS_RD_DATA:
          if (fall_ev && !byte_end)
          begin
            cnt_ff <= cnt_ff + 4'h1;
          end
        default:
          cnt_ff <= CNT_ZERO;
      endcase
    end
  end

  // receive shifter, direction and master acknowledge capture
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      rx_ff <= BYTE_RESET;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
    end
    else
    begin
      if (rise_ev && (state_ff == TWS_DEV_ADDR ||
          state_ff == TWS_REG_ADDR || state_ff == TWS_WR_DATA))
      begin
        rx_ff <= {rx_ff[6:0], sda_sync_ff};
      end
      if ((state_ff == TWS_DEV_ADDR) && byte_end)
      begin
        rw_ff <= rx_ff[0];
      end
      if ((state_ff == TWS_ACK_RD) && rise_ev)
      begin
        mack_ff <= !sda_sync_ff;
      end
    end
  end

  // transmit shifter, loaded at the end of a read's address acknowledge and of each master acknowledge
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      tx_ff <= BYTE_RESET;
    end
    else if (fall_ev && (((state_ff == TWS_ACK_DEV) && rw_ff) ||
             ((state_ff == TWS_ACK_RD) && mack_ff)))
    begin
      tx_ff <= next_tx;
    end
    else if ((state_ff == TWS_RD_DATA) && fall_ev && !byte_end)
    begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // open-drain data line: only ever pulled low, changed on clock fall
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      drive_low_ff <= 1'b0;
    end
    else if (start_ev || stop_ev)
    begin
      drive_low_ff <= 1'b0;
    end
    else if (fall_ev)
    begin
      case (state_ff)
        TWS_DEV_ADDR:
          drive_low_ff <= byte_end && addr_match;
        TWS_REG_ADDR:
          drive_low_ff <= byte_end;
        TWS_WR_DATA:
          drive_low_ff <= byte_end;
        TWS_ACK_DEV:
          drive_low_ff <= rw_ff && !next_tx[7];
        TWS_RD_DATA:
          drive_low_ff <= !byte_end && !tx_ff[6];
        TWS_ACK_RD:
          drive_low_ff <= mack_ff && !next_tx[7];
        default:
          drive_low_ff <= 1'b0;
      endcase
    end
  end

  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe_out = drive_low_ff;

  // register pointer and byte half
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      ptr_ff <= PTR_RESET;
      sel_ff <= 1'b0;
    end
    else if (regaddr_done)
    begin
      ptr_ff <= rx_ff;
      sel_ff <= 1'b0;
    end
    else if ((wrbyte_done || rdbyte_done) && !is_alias)
    begin
      sel_ff <= !sel_ff;
      if (sel_ff)
      begin
        ptr_ff <= ptr_ff + 8'h01;
      end
    end
  end

  // upper byte held until the word completes; alias bookkeeping
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      wr_hi_ff <= BYTE_RESET;
      alias_addr_ff <= PTR_RESET;
      alias_lo_ff <= BYTE_RESET;
    end
    else
    begin
      if (wrbyte_done && !is_alias && !sel_ff)
      begin
        wr_hi_ff <= rx_ff;
        alias_addr_ff <= ptr_ff;
      end
      if (rdbyte_done && !is_alias && !sel_ff)
      begin
        alias_lo_ff <= word_ff[7:0];
      end
    end
  end

  // request to the register side: optional write plus a fetch
  logic req_tgl_ff;
  logic req_we_ff;
  logic [7:0] req_waddr_ff;
  logic [15:0] req_wdata_ff;
  logic [7:0] req_raddr_ff;
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      req_tgl_ff <= 1'b0;
      req_we_ff <= 1'b0;
      req_waddr_ff <= PTR_RESET;
      req_wdata_ff <= WORD_RESET;
      req_raddr_ff <= PTR_RESET;
    end
    else if (regaddr_done)
    begin
      req_tgl_ff <= !req_tgl_ff;
      req_we_ff <= 1'b0;
      req_raddr_ff <= rx_ff;
    end
    else if (wrbyte_done && (is_alias || sel_ff))
    begin
      req_tgl_ff <= !req_tgl_ff;
      req_we_ff <= 1'b1;
      req_waddr_ff <= is_alias ? alias_addr_ff : ptr_ff;
      req_wdata_ff <= {wr_hi_ff, rx_ff};
      req_raddr_ff <= is_alias ? ptr_ff : ptr_ff + 8'h01;
    end
    else if (rdbyte_done && !is_alias && sel_ff)
    begin
      req_tgl_ff <= !req_tgl_ff;
      req_we_ff <= 1'b0;
      req_raddr_ff <= ptr_ff + 8'h01;
    end
  end

  // register side: toggle synchroniser and access pipeline
  logic rq_meta_ff, rq_sync_ff, rq_prev_ff;
  logic p1_ff, p2_ff;
  logic ack_tgl_ff;
  logic ref_we_ff;
  logic [7:0] ref_waddr_ff;
  logic [15:0] ref_wdata_ff;
  logic [7:0] ref_raddr_ff;
  logic [15:0] mem_rdata;
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rq_meta_ff <= 1'b0;
      rq_sync_ff <= 1'b0;
      rq_prev_ff <= 1'b0;
      p1_ff <= 1'b0;
      p2_ff <= 1'b0;
      ack_tgl_ff <= 1'b0;
    end
    else
    begin
      rq_meta_ff <= req_tgl_ff;
      rq_sync_ff <= rq_meta_ff;
      rq_prev_ff <= rq_sync_ff;
      p1_ff <= rq_sync_ff ^ rq_prev_ff;
      p2_ff <= p1_ff;
      if (p2_ff)
      begin
        ack_tgl_ff <= !ack_tgl_ff;
      end
    end
  end

  // request fields are stable here; latch them on the event
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ref_we_ff <= 1'b0;
      ref_waddr_ff <= PTR_RESET;
      ref_wdata_ff <= WORD_RESET;
      ref_raddr_ff <= PTR_RESET;
    end
    else if (rq_sync_ff ^ rq_prev_ff)
    begin
      ref_we_ff <= req_we_ff;
      ref_waddr_ff <= req_waddr_ff;
      ref_wdata_ff <= req_wdata_ff;
      ref_raddr_ff <= req_raddr_ff;
    end
  end

  tws_reg_mem #(
    .ADDR_W(REG_ADDR_W),
    .DATA_W(REG_DATA_W)
  ) u_mem (
    .clk_in(ref_clk_in),
    .wr_en_in(p1_ff && ref_we_ff),
    .wr_addr_in(ref_waddr_ff),
    .wr_data_in(ref_wdata_ff),
    .rd_a_addr_in(ref_raddr_ff),
    .rd_a_data_out(mem_rdata),
    .rd_b_addr_in(cfg_addr_in),
    .rd_b_data_out(cfg_data_out)
  );

  // fetched word returns on the acknowledge toggle
  logic ak_meta_ff, ak_sync_ff, ak_prev_ff;
  always_ff @(posedge link_sample_clk_in or negedge lrst_n_ff)
  begin
    if (!lrst_n_ff)
    begin
      ak_meta_ff <= 1'b0;
      ak_sync_ff <= 1'b0;
      ak_prev_ff <= 1'b0;
      word_ff <= WORD_RESET;
    end
    else
    begin
      ak_meta_ff <= ack_tgl_ff;
      ak_sync_ff <= ak_meta_ff;
      ak_prev_ff <= ak_sync_ff;
      if (ak_sync_ff ^ ak_prev_ff)
      begin
        word_ff <= mem_rdata;
      end
    end
  end

endmodule

// ### verif/two_wire_register_slave_bench.sv
`timescale 1ns/10ps
// bench: bus master model against the slave, register model in an associative array
module two_wire_register_slave_bench;
  import tws_pkg::*;
  logic ref_clk, link_clk, reset_n, sel, scl, m_pull, d_out, d_oe, sda;
  logic [7:0] cfg_addr;
  logic [15:0] cfg_data;
  logic [7:0] hi_byte, rd_lo;
  logic [15:0] mdl [int];
  int mismatches, checks_done, ptr, phase, hi_reg, r;
  // open-drain line with pull-up
  assign sda = !(m_pull || d_oe);
  always #5 ref_clk = ~ref_clk;
  always #15 link_clk = ~link_clk;
  tws_register_slave u_tws_register_slave (.ref_clk_in(ref_clk),
    .reset_n_in(reset_n), .link_sample_clk_in(link_clk),
    .bus_address_select_in(sel), .serial_clock_in(scl),
    .serial_data_line_in(sda), .serial_data_line_out(d_out),
    .serial_data_line_oe_out(d_oe), .cfg_addr_in(cfg_addr),
    .cfg_data_out(cfg_data));
  tws_bus_master u_tws_bus_master (.lclk_in(link_clk), .sda_in(sda),
    .scl_out(scl), .sda_pull_out(m_pull));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one byte to the device, low level means acknowledged
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_tws_bus_master.wr_byte(b, a);
    check("ack", {15'h0000, a}, {15'h0000, !exp_ack});
  endtask
  task automatic frame_open(input logic rd, input logic [7:0] ra);
    logic [7:0] ad;
    ad = sel ? BUS_ADDR_SEL_HIGH : BUS_ADDR_SEL_LOW;
    u_tws_bus_master.start();
    send(ad, 1'b1);
    send(ra, 1'b1);
    ptr = ra;
    phase = 0;
    if (rd)
    begin
      u_tws_bus_master.start();
      send(ad | 8'h01, 1'b1);
    end
  endtask
  // data byte on the bus and in the model
  task automatic wr_data(input logic [7:0] b);
    send(b, 1'b1);
    if (ptr == 8'h7F)
      mdl[hi_reg] = {hi_byte, b};
    else if (phase == 0)
    begin
      hi_byte = b;
      hi_reg = ptr;
      phase = 1;
    end
    else
    begin
      mdl[ptr] = {hi_byte, b};
      ptr = (ptr + 1) % 256;
      phase = 0;
    end
  endtask
  task automatic rd_data(input logic last);
    logic [7:0] b, e;
    u_tws_bus_master.rd_byte(last, b);
    if (ptr == 8'h7F)
      e = rd_lo;
    else if (phase == 0)
    begin
      e = mdl[ptr][15:8];
      rd_lo = mdl[ptr][7:0];
      phase = 1;
    end
    else
    begin
      e = mdl[ptr][7:0];
      ptr = (ptr + 1) % 256;
      phase = 0;
    end
    check("read byte", {8'h00, b}, {8'h00, e});
  endtask
  task automatic frame_wr(input logic [7:0] ra, input int n);
    frame_open(1'b0, ra);
    repeat (n) wr_data(8'($urandom));
    u_tws_bus_master.stop();
  endtask
  task automatic frame_rd(input logic [7:0] ra, input int n);
    frame_open(1'b1, ra);
    for (int i = 0; i < n; i++)
      rd_data(i == n - 1);
    u_tws_bus_master.stop();
  endtask
  task automatic cfg_chk(input logic [7:0] ra);
    @(negedge ref_clk);
    cfg_addr = ra;
    repeat (3) @(negedge ref_clk);
    check("register word", cfg_data, mdl[ra]);
  endtask
  // hang guard
  initial
  begin
    #900000;
    mismatches++;
    summarize();
  end
  initial
  begin
    ref_clk = 1'b0;
    link_clk = 1'b0;
    reset_n = 1'b0;
    sel = 1'b0;
    cfg_addr = 8'h00;
    mismatches = 0;
    checks_done = 0;
    ptr = 0;
    phase = 0;
    hi_reg = 0;
    hi_byte = 8'h00;
    rd_lo = 8'h00;
    void'($urandom(32'hD6DCF985));
    repeat (5) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (10) @(posedge link_clk);
    for (int s = 0; s < 2; s++)
    begin
      @(negedge ref_clk);
      sel = s[0];
      r = $urandom_range(1, 123);
      frame_wr(r[7:0], 2);
      frame_rd(r[7:0], 2);
      cfg_chk(r[7:0]);
    end
    $display("test address select done");
    r = $urandom_range(1, 123);
    frame_wr(r[7:0], 6);
    frame_rd(r[7:0], 6);
    cfg_chk(8'(r + 2));
    $display("test auto increment done");
    u_tws_bus_master.start();
    send(sel ? BUS_ADDR_SEL_LOW : BUS_ADDR_SEL_HIGH, 1'b0);
    send(8'h01, 1'b0);
    u_tws_bus_master.stop();
    $display("test foreign address done");
    r = $urandom_range(1, 123);
    frame_wr(r[7:0], 2);
    frame_wr(r[7:0], 1);
    cfg_chk(r[7:0]);
    frame_wr(8'h7F, 1);
    cfg_chk(r[7:0]);
    frame_rd(r[7:0], 1);
    frame_rd(8'h7F, 1);
    $display("test partial and byte-wide done");
    summarize();
  end
endmodule
bind tws_register_slave tws_register_slave_checker u_checker (
  .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
  .link_sample_clk_in(link_sample_clk_in),
  .bus_address_select_in(bus_address_select_in),
  .serial_clock_in(serial_clock_in),
  .serial_data_line_in(serial_data_line_in),
  .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe_out(serial_data_line_oe_out),
  .cfg_addr_in(cfg_addr_in), .cfg_data_out(cfg_data_out));

// ### verif/tws_bus_master.sv
`timescale 1ns/10ps
// bus master model: drives the clock, pulls data low or lets it float
module tws_bus_master (
  input wire logic lclk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // clock stands high and data floats while idle
  initial
  begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // quarter bit, changes land just after a sampling edge
  task automatic q();
    repeat (6) @(posedge lclk_in);
    #1;
  endtask
  // data falls while clock high
  task automatic start();
    sda_pull_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_pull_out = 1'b1;
    q();
    scl_out = 1'b0;
    q();
  endtask
  // data rises while clock high
  task automatic stop();
    sda_pull_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_pull_out = 1'b0;
    q();
  endtask
  // one clock pulse, data set only while clock low
  task automatic pulse(input logic pull, output logic seen);
    sda_pull_out = pull;
    q();
    scl_out = 1'b1;
    q();
    seen = sda_in;
    q();
    scl_out = 1'b0;
    q();
  endtask
  // msb first, then release for the device's acknowledge
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--)
      pulse(!b[i], d);
    pulse(1'b0, ack);
  endtask
  // read a byte, acknowledge unless it is the last
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic d;
    for (int i = 7; i >= 0; i--)
      pulse(1'b0, b[i]);
    pulse(!last, d);
  endtask
endmodule

// ### verif/tws_register_slave_checker.sv
`timescale 1ns/10ps
// link-side protocol checks on the device pins
module tws_register_slave_checker (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic link_sample_clk_in,
  input wire logic bus_address_select_in,
  input wire logic serial_clock_in,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe_out,
  input wire logic [tws_pkg::REG_ADDR_W-1:0] cfg_addr_in,
  input wire logic [tws_pkg::REG_DATA_W-1:0] cfg_data_out
);
  import tws_pkg::*;
  logic scl_ff, sda_ff, first_ff, mine_ff, rd_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] own;
  logic rise, start, stop, slot;
  default clocking @(posedge link_sample_clk_in); endclocking
  default disable iff (!reset_n_in);
  // bus events from the raw pins
  assign own = bus_address_select_in ? BUS_ADDR_SEL_HIGH : BUS_ADDR_SEL_LOW;
  assign rise = serial_clock_in && !scl_ff;
  assign start = serial_clock_in && scl_ff && sda_ff && !serial_data_line_in;
  assign stop = serial_clock_in && scl_ff && !sda_ff && serial_data_line_in;
  assign slot = rise && (cnt_ff == 4'h8);
  // bit count, shifted byte and frame kind
  always_ff @(posedge link_sample_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      first_ff <= 1'b0;
      mine_ff <= 1'b0;
      rd_ff <= 1'b0;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
    end
    else
    begin
      scl_ff <= serial_clock_in;
      sda_ff <= serial_data_line_in;
      if (start)
      begin
        cnt_ff <= 4'h0;
        first_ff <= 1'b1;
        mine_ff <= 1'b0;
      end
      else if (slot)
      begin
        cnt_ff <= 4'h0;
        first_ff <= 1'b0;
        if (first_ff)
        begin
          mine_ff <= (sh_ff[7:1] == own[7:1]);
          rd_ff <= sh_ff[0];
        end
      end
      else if (rise)
      begin
        cnt_ff <= cnt_ff + 4'h1;
        sh_ff <= {sh_ff[6:0], serial_data_line_in};
      end
    end
  end
  sequence s_quiet;
    !serial_data_line_oe_out [*8];
  endsequence
  sequence s_master_nack;
    slot && !first_ff && mine_ff && rd_ff && serial_data_line_in;
  endsequence
  a_ack_own_addr: assert property (
    slot && first_ff && sh_ff[7:1] == own[7:1] |-> serial_data_line_oe_out)
    else $error("own address not acknowledged");
  a_nack_foreign_addr: assert property (
    slot && first_ff && sh_ff[7:1] != own[7:1] |-> !serial_data_line_oe_out)
    else $error("foreign address acknowledged");
  a_ack_write_byte: assert property (
    slot && !first_ff && mine_ff && !rd_ff |-> serial_data_line_oe_out)
    else $error("written byte not acknowledged");
  a_silent_foreign: assert property (
    !first_ff && !mine_ff |-> !serial_data_line_oe_out)
    else $error("line driven in a foreign frame");
  a_release_rd_ack: assert property (
    slot && !first_ff && mine_ff && rd_ff |-> !serial_data_line_oe_out)
    else $error("line held in master acknowledge slot");
  a_release_on_nack: assert property (
    s_master_nack |=> s_quiet)
    else $error("line driven after master nack");
  a_steady_scl_high: assert property (
    serial_clock_in && $past(serial_clock_in) |-> $stable(serial_data_line_oe_out))
    else $error("data drive changed while clock high");
  a_out_pull_only: assert property (
    serial_data_line_out == 1'b0)
    else $error("data line driven high");
  a_stop_quiet: assert property (
    stop |-> s_quiet)
    else $error("line driven after stop");
  a_start_quiet: assert property (
    start |-> !serial_data_line_oe_out)
    else $error("line driven at start");
endmodule
